// ==== shared/uxrs_pkg.sv ====
// constants for the upper register set of the serial unit
// assumes byte addresses on an 8-bit offset, 32-bit data words
package uxrs_pkg;
  // queue geometry
  localparam int DEPTH = 16;
  localparam int LVL_W = 5;
  localparam int PTR_W = 4;
  // register offsets
  localparam logic [7:0] OFS_ALIAS_LO = 8'h30;
  localparam logic [7:0] OFS_ALIAS_HI = 8'h6C;
  localparam logic [7:0] OFS_TEST = 8'h70;
  localparam logic [7:0] OFS_PEEK = 8'h74;
  localparam logic [7:0] OFS_INJECT = 8'h78;
  localparam logic [7:0] OFS_STATUS = 8'h7C;
  localparam logic [7:0] OFS_TX_LVL = 8'h80;
  localparam logic [7:0] OFS_RX_LVL = 8'h84;
  localparam logic [7:0] OFS_SWRST = 8'h88;
  localparam logic [7:0] OFS_RTS = 8'h8C;
  localparam logic [7:0] OFS_BREAK = 8'h90;
  localparam logic [7:0] OFS_DMAM = 8'h94;
  localparam logic [7:0] OFS_QEN = 8'h98;
  localparam logic [7:0] OFS_RXTRIG = 8'h9C;
  localparam logic [7:0] OFS_TXTRIG = 8'hA0;
  localparam logic [7:0] OFS_HALT = 8'hA4;
  localparam logic [7:0] OFS_DMAACK = 8'hA8;
  localparam logic [7:0] OFS_PARAMS = 8'hF4;
  localparam logic [7:0] OFS_VERSION = 8'hF8;
  // field positions
  localparam int INJ_FE_BIT = 9;
  localparam int INJ_PE_BIT = 8;
  localparam int STAT_RXFULL = 4;
  localparam int STAT_RXNE = 3;
  localparam int STAT_TXE = 2;
  localparam int STAT_TXNF = 1;
  localparam int STAT_BUSY = 0;
  localparam int SWRST_UNIT = 0;
  localparam int SWRST_RXQ = 1;
  localparam int SWRST_TXQ = 2;
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_DMAM = 3;
  localparam int FCR_TXTRIG_LSB = 4;
  localparam int FCR_RXTRIG_LSB = 6;
  localparam int PAR_DEPTH_LSB = 16;
  localparam int PAR_EXTRA_DMA_SIGNAL_OPTION = 13;
  localparam int PAR_ADD_PARAMS = 12;
  localparam int PAR_SHADOW = 11;
  localparam int PAR_FIFO_STAT = 10;
  localparam int PAR_FIFO_ACCESS = 9;
  localparam int PAR_ADD_FEAT = 8;
  localparam int PAR_THRE = 5;
  // encoded values and reset values
  localparam logic [7:0] PAR_DEPTH_NONE = 8'h00;
  localparam logic [7:0] PAR_DEPTH_16 = 8'h01;
  localparam logic [1:0] PAR_BUS32 = 2'h2;
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic RST_BIT = 1'b0;

  // word-aligned offset inside the burst alias window
  function automatic logic in_alias(input logic [7:0] a);
    return (a >= OFS_ALIAS_LO) && (a <= OFS_ALIAS_HI) && (a[1:0] == 2'h0);
  endfunction
endpackage

// ==== rtl/uxrs_rst_sync.sv ====
// reset combiner: system reset or software unit reset
// assumes unit_req comes from a flop outside the reset it creates
`timescale 1ns/1ps
module uxrs_rst_sync (
  // clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic unit_req,
  // synchronised reset
  output logic rst_n
);
  logic clr_n;
  logic stage_ff;
  logic out_ff;

  // assert at once, release on the clock
  assign clr_n = arst_n & ~unit_req;

  // two-stage release
  always_ff @(posedge clk or negedge clr_n) begin
    if (!clr_n) begin
      stage_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      stage_ff <= 1'b1;
      out_ff <= stage_ff;
    end
  end

  assign rst_n = out_ff;
endmodule // uxrs_rst_sync

// ==== rtl/uxrs_fifo.sv ====
// 16-entry queue with level, flush and a one-deep holding mode
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module uxrs_fifo #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic flush,
  input wire logic one_deep,
  // write side
  input wire logic push,
  input wire logic [W-1:0] wdata,
  // read side
  input wire logic pop,
  output logic [W-1:0] rdata,
  // state
  output logic [uxrs_pkg::LVL_W-1:0] level,
  output logic empty,
  output logic full
);
  logic [W-1:0] mem [uxrs_pkg::DEPTH];
  logic [uxrs_pkg::PTR_W-1:0] wr_ptr_ff;
  logic [uxrs_pkg::PTR_W-1:0] rd_ptr_ff;
  logic [uxrs_pkg::LVL_W-1:0] cnt_ff;
  logic do_push;
  logic do_pop;

  // holding mode behaves as a single register
  assign empty = (cnt_ff == '0);
  assign full = one_deep ? !empty
                         : (cnt_ff == uxrs_pkg::LVL_W'(uxrs_pkg::DEPTH));
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign rdata = mem[rd_ptr_ff];
  assign level = cnt_ff;

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= wdata;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else if (flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (do_push && !do_pop) cnt_ff <= cnt_ff + 1'b1;
      else if (do_pop && !do_push) cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule // uxrs_fifo

// ==== rtl/uxrs_top.sv ====
// upper register set of the serial unit: aliases, queue test access,
// status, levels, software reset, halt, build parameters, version
// assumes APB-style master, base registers and line engine on clk
// Contract
// - with aliases on and divisor access off, 0x30-0x6C read/write data queues
// - test access bit always readable; writes ignored without test option
// - in test mode, peek returns transmit queue head
// - in test mode, inject pushes byte, parity and framing flags
// - status bits 4 and 3 show receive full and not empty
// - status bits 2 and 1 show transmit empty and not full
// - status bit 0 shows a transfer in progress
// - two registers report transmit and receive queue levels
// - unit reset bit asserts reset at once, released on the clock
// - reset register bits flush the receive and transmit queues
// - request-to-send alias shares storage with the modem control bit
// - break alias shares storage with the line control bit
// - dma mode alias shares storage with queue control bit 3
// - queue enable alias shares storage with queue control bit 0
// - receive trigger alias holds the two-bit trigger encoding
// - transmit empty trigger alias holds the two-bit threshold
// - halt bit stops transmission; ignored without queues
// - dma acknowledge write ends a transfer only with the dma option
// - parameter bits 23:16 encode queue depth
// - parameter bits 13:5 list options, bits 1:0 bus width
// - version register returns ascii digits and an asterisk
`timescale 1ns/1ps
module uxrs_top #(
  parameter bit HAS_FIFO = 1'b1,
  parameter bit SHADOW = 1'b1,
  parameter bit FIFO_ACCESS = 1'b1,
  parameter bit FIFO_STAT = 1'b1,
  parameter bit EXTRA_DMA_SIGNAL_OPTION = 1'b1,
  parameter bit THRE_USER = 1'b1,
  parameter bit ADD_PARAMS = 1'b1,
  parameter bit ADD_FEAT = 1'b1,
  // arbitrary value, reads as "100*"
  parameter logic [31:0] VERSION = 32'h3130302A
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // base register side
  input wire logic lcr_div_access,
  input wire logic base_mcr_we,
  input wire logic base_mcr_rts,
  input wire logic base_lcr_we,
  input wire logic base_lcr_break,
  input wire logic base_fcr_we,
  input wire logic [7:0] base_fcr_wdata,
  // line engine side
  input wire logic busy_in,
  input wire logic tx_pop,
  output logic [7:0] tx_byte,
  output logic tx_avail,
  input wire logic rx_push,
  input wire logic [7:0] rx_byte,
  input wire logic rx_fe,
  input wire logic rx_pe,
  output logic [1:0] rx_head_err,
  // shared control state
  output logic rts,
  output logic line_break,
  output logic dma_mode,
  output logic queue_enable,
  output logic [1:0] rx_trigger,
  output logic [1:0] tx_empty_trigger,
  output logic transmit_halt,
  output logic dma_ack,
  output logic unit_rst_n
);
  logic rst_n;
  logic unit_req_ff;
  logic wr;
  logic rd_setup;
  logic alias_hit;
  logic [31:0] rd_val;
  logic mapped;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic test_ff;
  logic rts_ff;
  logic break_ff;
  logic dma_mode_ff;
  logic qen_ff;
  logic [1:0] rx_trig_ff;
  logic [1:0] tx_trig_ff;
  logic halt_ff;
  logic dma_ack_ff;
  logic [7:0] tx_byte_ff;
  logic tx_avail_ff;
  logic [1:0] rx_err_ff;
  logic nxt_qen;
  logic qen_change;
  logic tx_push;
  logic tx_pop_eff;
  logic tx_flush;
  logic [7:0] tx_rdata;
  logic [4:0] tx_level;
  logic tx_empty;
  logic tx_full;
  logic inject;
  logic rx_push_eff;
  logic [9:0] rx_wdata;
  logic rx_pop;
  logic rx_flush;
  logic [9:0] rx_rdata;
  logic [4:0] rx_level;
  logic rx_empty;
  logic rx_full;

  // bus phases
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign alias_hit = SHADOW && !lcr_div_access && uxrs_pkg::in_alias(paddr);

  // unit reset request, lives only on the system reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) unit_req_ff <= 1'b0;
    else unit_req_ff <= wr && SHADOW && (paddr == uxrs_pkg::OFS_SWRST)
                        && pwdata[uxrs_pkg::SWRST_UNIT];
  end

  uxrs_rst_sync u_rst (
    .clk(clk),
    .arst_n(arst_n),
    .unit_req(unit_req_ff),
    .rst_n(rst_n)
  );

  // transmit queue, filled through the alias window
  uxrs_fifo #(.W(8)) u_txq (
    .clk(clk),
    .rst_n(rst_n),
    .flush(tx_flush),
    .one_deep(!qen_ff),
    .push(tx_push),
    .wdata(pwdata[7:0]),
    .pop(tx_pop_eff),
    .rdata(tx_rdata),
    .level(tx_level),
    .empty(tx_empty),
    .full(tx_full)
  );

  // receive queue holds {framing, parity, data}
  uxrs_fifo #(.W(10)) u_rxq (
    .clk(clk),
    .rst_n(rst_n),
    .flush(rx_flush),
    .one_deep(!qen_ff),
    .push(rx_push_eff),
    .wdata(rx_wdata),
    .pop(rx_pop),
    .rdata(rx_rdata),
    .level(rx_level),
    .empty(rx_empty),
    .full(rx_full)
  );

  // queue push and pop through the alias
  assign tx_push = wr && alias_hit;
  assign rx_pop = rd_setup && alias_hit;
  assign tx_pop_eff = tx_pop && tx_avail_ff;
  // injected entries take the push port over the receiver
  assign inject = wr && FIFO_ACCESS && test_ff
                  && (paddr == uxrs_pkg::OFS_INJECT);
  assign rx_push_eff = inject || rx_push;
  assign rx_wdata = inject ? {pwdata[uxrs_pkg::INJ_FE_BIT],
                              pwdata[uxrs_pkg::INJ_PE_BIT], pwdata[7:0]}
                           : {rx_fe, rx_pe, rx_byte};

  // next queue enable from either path
  always_comb begin
    nxt_qen = qen_ff;
    if (base_fcr_we && HAS_FIFO) nxt_qen = base_fcr_wdata[uxrs_pkg::FCR_EN];
    if (wr && SHADOW && HAS_FIFO && (paddr == uxrs_pkg::OFS_QEN)) begin
      nxt_qen = pwdata[0];
    end
  end
  assign qen_change = (nxt_qen != qen_ff);

  // queue flushes from reset register, queue control, mode change
  assign rx_flush = qen_change
    || (base_fcr_we && base_fcr_wdata[uxrs_pkg::FCR_RXRST])
    || (wr && SHADOW && (paddr == uxrs_pkg::OFS_SWRST)
        && pwdata[uxrs_pkg::SWRST_RXQ]);
  assign tx_flush = qen_change
    || (base_fcr_we && base_fcr_wdata[uxrs_pkg::FCR_TXRST])
    || (wr && SHADOW && (paddr == uxrs_pkg::OFS_SWRST)
        && pwdata[uxrs_pkg::SWRST_TXQ]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) test_ff <= uxrs_pkg::RST_BIT;
    else if (wr && FIFO_ACCESS && (paddr == uxrs_pkg::OFS_TEST)) begin
      test_ff <= pwdata[0];
    end
  end

  // request to send, modem control and alias share one bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rts_ff <= uxrs_pkg::RST_BIT;
    else if (wr && SHADOW && (paddr == uxrs_pkg::OFS_RTS)) begin
      rts_ff <= pwdata[0];
    end else if (base_mcr_we) rts_ff <= base_mcr_rts;
  end

  // break control, line control and alias share one bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) break_ff <= uxrs_pkg::RST_BIT;
    else if (wr && SHADOW && (paddr == uxrs_pkg::OFS_BREAK)) begin
      break_ff <= pwdata[0];
    end else if (base_lcr_we) break_ff <= base_lcr_break;
  end

  // queue control fields, one store per field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_mode_ff <= uxrs_pkg::RST_BIT;
      qen_ff <= uxrs_pkg::RST_BIT;
      rx_trig_ff <= uxrs_pkg::RST_TRIG;
      tx_trig_ff <= uxrs_pkg::RST_TRIG;
    end else begin
      qen_ff <= nxt_qen;
      if (base_fcr_we && HAS_FIFO) begin
        dma_mode_ff <= base_fcr_wdata[uxrs_pkg::FCR_DMAM];
        rx_trig_ff <= base_fcr_wdata[uxrs_pkg::FCR_RXTRIG_LSB +: 2];
        if (THRE_USER) begin
          tx_trig_ff <= base_fcr_wdata[uxrs_pkg::FCR_TXTRIG_LSB +: 2];
        end
      end
      if (wr && SHADOW && HAS_FIFO) begin
        if (paddr == uxrs_pkg::OFS_DMAM) dma_mode_ff <= pwdata[0];
        if (paddr == uxrs_pkg::OFS_RXTRIG) rx_trig_ff <= pwdata[1:0];
      end
      if (wr && HAS_FIFO && THRE_USER && (paddr == uxrs_pkg::OFS_TXTRIG)) begin
        tx_trig_ff <= pwdata[1:0];
      end
    end
  end

  // transmit halt, only with queues; dma acknowledge pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_ff <= uxrs_pkg::RST_BIT;
      dma_ack_ff <= uxrs_pkg::RST_BIT;
    end else begin
      if (wr && HAS_FIFO && (paddr == uxrs_pkg::OFS_HALT)) begin
        halt_ff <= pwdata[0];
      end
      dma_ack_ff <= wr && EXTRA_DMA_SIGNAL_OPTION && (paddr == uxrs_pkg::OFS_DMAACK)
                    && pwdata[0];
    end
  end

  // head of transmit queue offered to the line engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_byte_ff <= '0;
      tx_avail_ff <= 1'b0;
      rx_err_ff <= 2'h0;
    end else begin
      tx_byte_ff <= tx_rdata;
      tx_avail_ff <= !tx_empty && !halt_ff && !tx_pop_eff && !tx_flush;
      rx_err_ff <= rx_empty ? 2'h0 : rx_rdata[9:8];
    end
  end

  // read decode and values
  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    if (alias_hit) begin
      rd_val[7:0] = rx_rdata[7:0];
    end else begin
      case (paddr)
        uxrs_pkg::OFS_TEST: rd_val[0] = test_ff;
        // head of transmit queue in test mode
        uxrs_pkg::OFS_PEEK: begin
          mapped = FIFO_ACCESS;
          if (FIFO_ACCESS && test_ff) rd_val[7:0] = tx_rdata;
        end
        uxrs_pkg::OFS_INJECT: mapped = FIFO_ACCESS;
        uxrs_pkg::OFS_STATUS: begin
          rd_val[uxrs_pkg::STAT_BUSY] = busy_in;
          if (FIFO_STAT) begin
            rd_val[uxrs_pkg::STAT_RXFULL] = rx_full;
            rd_val[uxrs_pkg::STAT_RXNE] = !rx_empty;
            rd_val[uxrs_pkg::STAT_TXE] = tx_empty;
            rd_val[uxrs_pkg::STAT_TXNF] = !tx_full;
          end
        end
        uxrs_pkg::OFS_TX_LVL: begin
          mapped = FIFO_STAT;
          if (FIFO_STAT) rd_val[4:0] = tx_level;
        end
        uxrs_pkg::OFS_RX_LVL: begin
          mapped = FIFO_STAT;
          if (FIFO_STAT) rd_val[4:0] = rx_level;
        end
        uxrs_pkg::OFS_SWRST: mapped = SHADOW;
        uxrs_pkg::OFS_RTS: begin
          mapped = SHADOW;
          if (SHADOW) rd_val[0] = rts_ff;
        end
        uxrs_pkg::OFS_BREAK: begin
          mapped = SHADOW;
          if (SHADOW) rd_val[0] = break_ff;
        end
        uxrs_pkg::OFS_DMAM: begin
          mapped = SHADOW && HAS_FIFO;
          if (mapped) rd_val[0] = dma_mode_ff;
        end
        uxrs_pkg::OFS_QEN: begin
          mapped = SHADOW && HAS_FIFO;
          if (mapped) rd_val[0] = qen_ff;
        end
        uxrs_pkg::OFS_RXTRIG: begin
          mapped = SHADOW && HAS_FIFO;
          if (mapped) rd_val[1:0] = rx_trig_ff;
        end
        uxrs_pkg::OFS_TXTRIG: begin
          mapped = HAS_FIFO && THRE_USER;
          if (mapped) rd_val[1:0] = tx_trig_ff;
        end
        uxrs_pkg::OFS_HALT: rd_val[0] = halt_ff;
        uxrs_pkg::OFS_DMAACK: rd_val = '0;
        uxrs_pkg::OFS_PARAMS: begin
          mapped = ADD_PARAMS;
          if (ADD_PARAMS) begin
            rd_val[uxrs_pkg::PAR_DEPTH_LSB +: 8] =
              HAS_FIFO ? uxrs_pkg::PAR_DEPTH_16 : uxrs_pkg::PAR_DEPTH_NONE;
            rd_val[uxrs_pkg::PAR_EXTRA_DMA_SIGNAL_OPTION] = EXTRA_DMA_SIGNAL_OPTION;
            rd_val[uxrs_pkg::PAR_ADD_PARAMS] = ADD_PARAMS;
            rd_val[uxrs_pkg::PAR_SHADOW] = SHADOW;
            rd_val[uxrs_pkg::PAR_FIFO_STAT] = FIFO_STAT;
            rd_val[uxrs_pkg::PAR_FIFO_ACCESS] = FIFO_ACCESS;
            rd_val[uxrs_pkg::PAR_ADD_FEAT] = ADD_FEAT;
            rd_val[uxrs_pkg::PAR_THRE] = THRE_USER;
            rd_val[1:0] = uxrs_pkg::PAR_BUS32;
          end
        end
        uxrs_pkg::OFS_VERSION: begin
          mapped = ADD_FEAT;
          if (ADD_FEAT) rd_val = VERSION;
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  // bus answer, captured in the setup phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      if (rd_setup) prdata_ff <= rd_val;
    end
  end

  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_byte = tx_byte_ff;
  assign tx_avail = tx_avail_ff;
  assign rx_head_err = rx_err_ff;
  assign rts = rts_ff;
  assign line_break = break_ff;
  assign dma_mode = dma_mode_ff;
  assign queue_enable = qen_ff;
  assign rx_trigger = rx_trig_ff;
  assign tx_empty_trigger = tx_trig_ff;
  assign transmit_halt = halt_ff;
  assign dma_ack = dma_ack_ff;
  assign unit_rst_n = rst_n;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_alias_push;
    wr && alias_hit && !tx_full && !tx_pop_eff && !tx_flush
      |=> tx_level == 5'($past(tx_level) + 5'h1);
  endproperty
  a_alias_push: assert property (p_alias_push)
    else $error("alias write did not fill transmit queue");

  property p_test_locked;
    wr && (paddr == uxrs_pkg::OFS_TEST)
      |=> test_ff == (FIFO_ACCESS ? $past(pwdata[0]) : $past(test_ff));
  endproperty
  a_test_locked: assert property (p_test_locked)
    else $error("test access bit wrong after write");

  property p_peek;
    rd_setup && (paddr == uxrs_pkg::OFS_PEEK) && test_ff && FIFO_ACCESS
      |=> prdata[7:0] == $past(tx_rdata);
  endproperty
  a_peek: assert property (p_peek)
    else $error("peek did not return transmit head");

  property p_inject;
    inject && !rx_full && !rx_flush
      |=> rx_level == 5'($past(rx_level) + 5'h1);
  endproperty
  a_inject: assert property (p_inject)
    else $error("inject did not fill receive queue");

  property p_status;
    rd_setup && (paddr == uxrs_pkg::OFS_STATUS) && FIFO_STAT
      |=> prdata[4:0] == {$past(rx_full), !$past(rx_empty),
                          $past(tx_empty), !$past(tx_full), $past(busy_in)};
  endproperty
  a_status: assert property (p_status)
    else $error("status bits do not match queue state");

  property p_level;
    rd_setup && (paddr == uxrs_pkg::OFS_RX_LVL) && FIFO_STAT
      |=> prdata[4:0] == $past(rx_level) ##1 !pready;
  endproperty
  a_level: assert property (p_level)
    else $error("receive level read back wrong");

  property p_unit_reset;
    @(posedge clk) disable iff (!arst_n)
    wr && SHADOW && (paddr == uxrs_pkg::OFS_SWRST)
      && pwdata[uxrs_pkg::SWRST_UNIT] |=> ##[0:1] !unit_rst_n;
  endproperty
  a_unit_reset: assert property (p_unit_reset)
    else $error("software unit reset not applied");

  property p_rts_alias;
    wr && SHADOW && (paddr == uxrs_pkg::OFS_RTS)
      |=> rts == $past(pwdata[0]);
  endproperty
  a_rts_alias: assert property (p_rts_alias)
    else $error("rts alias write not seen on modem control bit");

  property p_halt_stalls;
    halt_ff |=> !tx_avail;
  endproperty
  a_halt_stalls: assert property (p_halt_stalls)
    else $error("transmit offered while halted");

  c_alias_burst: cover property (tx_push ##3 tx_push);
  c_inject: cover property (inject);
  c_rx_full: cover property (rx_full && !rx_empty);
  c_halt: cover property (halt_ff && !tx_empty);
endmodule // uxrs_top

// ==== verif/uxrs_apb_master.sv ====
// bus master model for the register bus of the upper register set
// assumes one clock; requests launched 1 ns after a rising edge
`timescale 1ns/1ps
module uxrs_apb_master (
  // clock
  input wire logic clk,
  // register bus
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end

  // one setup plus access transfer, held until ready is seen
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    #1 {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
    @(posedge clk);
    #1 penable = 1'b1;
    // answer taken at the rising edge where ready is high
    @(posedge clk);
    while (pready !== 1'b1 && n < 8) begin
      n++;
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    // no ready within the limit: poison the answer
    if (n == 8) {q, e} = 'x;
    // released data is scrambled, not left stale
    #1 {psel, penable, pwdata} = {2'b00, ~d};
  endtask
endmodule // uxrs_apb_master

// ==== verif/tb_top.sv ====
// self-checking bench: queue model in the bench against uxrs_top
// assumes default parameters and the bus master model
`timescale 1ns/1ps
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, x); end end
module tb_top;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, tx_byte, base_fcr_wdata, rx_byte;
  logic [31:0] pwdata, prdata, q;
  logic lcr_div_access, base_mcr_we, base_mcr_rts, base_lcr_we;
  logic base_lcr_break, base_fcr_we, busy_in, tx_pop, tx_avail, rx_push;
  logic rx_fe, rx_pe, rts, line_break, dma_mode, queue_enable;
  logic transmit_halt, dma_ack, unit_rst_n;
  logic [1:0] rx_head_err, rx_trigger, tx_empty_trigger;
  logic [9:0] v;
  logic [9:0] rxq[$];
  logic [7:0] txq[$];
  int err_count, n_checks, cyc;

  uxrs_apb_master i_uxrs_apb_master (.clk, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  uxrs_top i_uxrs_top (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .lcr_div_access, .base_mcr_we,
    .base_mcr_rts, .base_lcr_we, .base_lcr_break, .base_fcr_we,
    .base_fcr_wdata, .busy_in, .tx_pop, .tx_byte, .tx_avail, .rx_push,
    .rx_byte, .rx_fe, .rx_pe, .rx_head_err, .rts, .line_break, .dma_mode,
    .queue_enable, .rx_trigger, .tx_empty_trigger, .transmit_halt,
    .dma_ack, .unit_rst_n);

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_uxrs_apb_master.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x);
    i_uxrs_apb_master.xfer(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      final_report();
    end
  end

  // main sequence
  initial begin
    {arst_n, lcr_div_access, base_mcr_we, base_mcr_rts, base_lcr_we} = '0;
    {base_lcr_break, base_fcr_we, base_fcr_wdata, busy_in, tx_pop} = '0;
    {rx_push, rx_byte, rx_fe, rx_pe} = '0;
    v = 10'($urandom(25));
    tick(20);
    arst_n = 1'b1;
    tick(3);
    rd(8'h7C, 32'h6);
    rd(8'h80, 32'h0);
    rd(8'hF4, 32'h00013F22);
    rd(8'hF8, 32'h3130302A);
    busy_in = 1'b1;
    rd(8'h7C, 32'h7);
    busy_in = 1'b0;
    wr(8'h98, 32'h1);
    `CHK(queue_enable, 1'b1)
    wr(8'h70, 32'h1);
    rd(8'h70, 32'h1);
    // fill receive queue by injection, then drain by burst
    for (int i = 0; i < 16; i++) begin
      v = 10'($urandom());
      wr(8'h78, {22'h0, v});
      rxq.push_back(v);
    end
    rd(8'h84, 32'd16);
    rd(8'h7C, 32'h1E);
    for (int i = 0; i < 16; i++) begin
      v = rxq.pop_front();
      `CHK(rx_head_err, v[9:8])
      rd(8'h30 + 8'(4 * i), {24'h0, v[7:0]});
    end
    // transmit through the alias window
    for (int i = 0; i < 4; i++) begin
      v = 10'($urandom());
      wr(8'h6C - 8'(4 * i), {24'h0, v[7:0]});
      txq.push_back(v[7:0]);
    end
    rd(8'h80, 32'd4);
    rd(8'h74, {24'h0, txq[0]});
    `CHK(tx_avail, 1'b1)
    tx_pop = 1'b1;
    tick(1);
    tx_pop = 1'b0;
    void'(txq.pop_front());
    tick(2);
    `CHK(tx_byte, txq[0])
    wr(8'hA4, 32'h1);
    tick(2);
    `CHK({transmit_halt, tx_avail}, 2'b10)
    wr(8'h88, 32'h6);
    rd(8'h80, 32'h0);
    lcr_div_access = 1'b1;
    i_uxrs_apb_master.xfer(1'b1, 8'h30, 32'h5A, q, e);
    `CHK(e, 1'b1)
    lcr_div_access = 1'b0;
    // receiver entry
    {rx_fe, rx_pe, rx_byte} = v;
    rx_push = 1'b1;
    tick(1);
    rx_push = 1'b0;
    rd(8'h84, 32'h1);
    rd(8'h30, {24'h0, v[7:0]});
    // control aliases and shared storage
    wr(8'h8C, 32'h1);
    wr(8'h90, 32'h1);
    wr(8'h94, 32'h1);
    rd(8'h94, 32'h1);
    `CHK({rts, line_break, dma_mode}, 3'b111)
    {base_mcr_we, base_lcr_we} = 2'b11;
    tick(1);
    {base_mcr_we, base_lcr_we} = 2'b00;
    rd(8'h8C, 32'h0);
    rd(8'h90, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h9C, i);
      `CHK(rx_trigger, 2'(i))
      wr(8'hA0, i);
      rd(8'hA0, i);
      `CHK(tx_empty_trigger, 2'(i))
    end
    // base queue control write lands in the shared stores
    {base_fcr_we, base_fcr_wdata} = {1'b1, 8'h41};
    tick(1);
    base_fcr_we = 1'b0;
    rd(8'h94, 32'h0);
    rd(8'h9C, 32'h1);
    rd(8'hA0, 32'h0);
    // dma acknowledge pulse
    wr(8'hA8, 32'h1);
    `CHK(dma_ack, 1'b1)
    tick(1);
    `CHK(dma_ack, 1'b0)
    // software unit reset
    wr(8'h88, 32'h1);
    e = 1'b1;
    repeat (6) begin
      @(negedge clk);
      if (unit_rst_n === 1'b0) e = 1'b0;
    end
    `CHK(e, 1'b0)
    tick(4);
    rd(8'h98, 32'h0);
    rd(8'h9C, 32'h0);
    final_report();
  end
endmodule // tb_top
